// ---- rtl/dxlc_pkg.sv ----
// Package for the DSX-1 port loopback control block.
// Assumes a single 100 MHz clock domain and a plain register port.
package dxlc_pkg;

  // Register offsets (byte addresses, one word each)
  localparam logic [7:0] DXLC_REG_CTRL = 8'h00;
  localparam logic [7:0] DXLC_REG_STAT = 8'h04;
  localparam logic [7:0] DXLC_REG_IRQ = 8'h08;
  localparam logic [7:0] DXLC_REG_MASK = 8'h0C;
  localparam logic [7:0] DXLC_REG_XC = 8'h10;

  // Control field positions
  localparam int DXLC_CTRL_LBMODE_LSB = 0;
  localparam int DXLC_CTRL_IFEN = 2;
  localparam int DXLC_CTRL_ESF = 3;
  localparam int DXLC_CTRL_B8ZS = 4;
  localparam int DXLC_CTRL_AOS = 5;

  // Status and event bit positions
  localparam int DXLC_EV_LB_ON = 0;
  localparam int DXLC_EV_LB_OFF = 1;
  localparam int DXLC_EV_FAIL = 2;
  localparam int DXLC_EV_W = 3;

  // Loopback pattern counters
  localparam int DXLC_V54_PAT_W = 7;
  localparam int DXLC_FT1_PAT_W = 10;
  localparam logic [DXLC_V54_PAT_W-1:0] DXLC_V54_SEED = 7'h7F;
  localparam int DXLC_DETECT_BITS = 2048;
  localparam int DXLC_ERR_LIMIT = 16;

  // Cross-connect map width (24 DS0 slots)
  localparam int DXLC_SLOTS = 24;

  typedef enum logic [1:0] {
    DXLC_LB_IGNORE,
    DXLC_LB_V54,
    DXLC_LB_FT1,
    DXLC_LB_EITHER
  } dxlc_lbmode_t;

  typedef struct packed {
    logic [DXLC_SLOTS-1:0] xc_map;
    dxlc_lbmode_t lb_mode;
    logic if_en;
    logic esf;
    logic b8zs;
    logic aos_en;
  } dxlc_cfg_t;

  // Control reset: ignore, disabled, ESF, B8ZS, substitution on
  localparam dxlc_cfg_t DXLC_CFG_RST = '{
    xc_map: '0, lb_mode: DXLC_LB_IGNORE, if_en: 1'b0,
    esf: 1'b1, b8zs: 1'b1, aos_en: 1'b1};

  typedef struct packed {
    logic act;
    logic rel;
  } dxlc_det_t;

endpackage : dxlc_pkg

// ---- rtl/dxlc_pat_det.sv ----
// Pattern detector for in-band loopback actuate and release codes.
// Assumes one received data bit per valid strobe, same clock.
`timescale 1ns/10ps
`default_nettype none
module dxlc_pat_det
  import dxlc_pkg::*;
#(
  parameter int LEN = 10,
  parameter logic [LEN-1:0] ACT_PAT = '0,
  parameter logic [LEN-1:0] REL_PAT = '0,
  parameter int WIN = DXLC_DETECT_BITS
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Bit stream
  input wire logic bit_vld,
  input wire logic bit_in,
  // Detections, one-cycle pulses
  output dxlc_det_t det
);

  typedef struct packed {
    logic [LEN-1:0] shreg;
    logic [11:0] act_cnt;
    logic [11:0] rel_cnt;
    dxlc_det_t det;
  } dxlc_pd_st_t;

  dxlc_pd_st_t st, next_st;
  logic [LEN-1:0] sh_new;

  // Count bits matching a repeating pattern; hit after WIN bits
  always_comb begin
    next_st = st;
    sh_new = {st.shreg[LEN-2:0], bit_in};
    next_st.det = '0;
    if (bit_vld) begin
      next_st.shreg = sh_new;
      if (sh_new == ACT_PAT) begin
        next_st.act_cnt = st.act_cnt + 12'(LEN);
      end else if (st.shreg[LEN-1] != bit_in) begin
        next_st.act_cnt = '0;
      end
      if (sh_new == REL_PAT) begin
        next_st.rel_cnt = st.rel_cnt + 12'(LEN);
      end else if (st.shreg[LEN-1] != bit_in) begin
        next_st.rel_cnt = '0;
      end
      if (st.act_cnt >= 12'(WIN)) begin
        next_st.det.act = 1'b1;
        next_st.act_cnt = '0;
      end
      if (st.rel_cnt >= 12'(WIN)) begin
        next_st.det.rel = 1'b1;
        next_st.rel_cnt = '0;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign det = st.det;

endmodule : dxlc_pat_det
`default_nettype wire

// ---- rtl/dxlc_top.sv ----
// DSX-1 port loopback control: config registers, loopback detection,
// failure substitution and data steering.
// Line status inputs pass through two-flop synchronisers onto mclk.
//
// Our own choices: strobed register access and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module dxlc_top
  import dxlc_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  // DSX-1 line status
  input wire logic loss_of_signal,
  input wire logic alarm_indication_signal,
  input wire logic out_of_frame,
  // Network receive stream and port permission
  input wire logic net_vld,
  input wire logic net_bit,
  input wire logic [4:0] net_slot,
  input wire logic lb_permit,
  // DSX-1 receive stream
  input wire logic dsx_bit,
  // Outputs toward network and DSX-1
  output logic net_tx_bit,
  output logic net_tx_vld,
  output logic dsx_tx_bit,
  output logic data_channel_loopback,
  output logic esf_mode,
  output logic b8zs_mode,
  output logic alarm,
  output logic led,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    dxlc_cfg_t cfg;
    logic lb;
    logic [DXLC_EV_W-1:0] evt;
    logic [DXLC_EV_W-1:0] mask;
    logic fail_d;
    logic [31:0] rdata;
    logic net_tx_bit;
    logic net_tx_vld;
    logic dsx_tx_bit;
    logic alarm;
    logic led;
    logic irq;
  } dxlc_st_t;

  dxlc_st_t st, next_st;
  dxlc_det_t v54_det, ft1_det;
  logic [1:0] lsync_a, lsync_b, lsync_c;
  logic line_fail, act_hit, rel_hit, slot_on;
  logic [DXLC_EV_W-1:0] ev_set;

  ////////////////////////////////////////////////////////////////////
  // Pattern detectors

  // V.54 style: repeating 7-bit actuate / release codes
  dxlc_pat_det #(
    .LEN(DXLC_V54_PAT_W),
    .ACT_PAT(7'h3C),
    .REL_PAT(7'h43),
    .WIN(DXLC_DETECT_BITS)
  ) u_v54 (
    .mclk(mclk),
    .rst(rst),
    .bit_vld(net_vld),
    .bit_in(net_bit),
    .det(v54_det)
  );

  // Fractional T1 in-band: repeating 10-bit codes
  dxlc_pat_det #(
    .LEN(DXLC_FT1_PAT_W),
    .ACT_PAT(10'h0D2),
    .REL_PAT(10'h0A4),
    .WIN(DXLC_DETECT_BITS)
  ) u_ft1 (
    .mclk(mclk),
    .rst(rst),
    .bit_vld(net_vld),
    .bit_in(net_bit),
    .det(ft1_det)
  );

  ////////////////////////////////////////////////////////////////////
  // Line status synchronisers; only the second stage is read by logic

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      lsync_a <= '0;
      lsync_b <= '0;
      lsync_c <= '0;
    end else begin
      lsync_a <= {lsync_a[0], loss_of_signal};
      lsync_b <= {lsync_b[0], alarm_indication_signal};
      lsync_c <= {lsync_c[0], out_of_frame};
    end
  end

  // Failure only counts while the interface is enabled
  assign line_fail = st.cfg.if_en &
                     (lsync_a[1] | lsync_b[1] | lsync_c[1]);

  ////////////////////////////////////////////////////////////////////
  // Mode selection of detections

  always_comb begin
    act_hit = 1'b0;
    rel_hit = 1'b0;
    unique case (st.cfg.lb_mode)
      DXLC_LB_IGNORE: begin
        act_hit = 1'b0;
        rel_hit = 1'b0;
      end
      DXLC_LB_V54: begin
        act_hit = v54_det.act;
        rel_hit = v54_det.rel;
      end
      DXLC_LB_FT1: begin
        act_hit = ft1_det.act;
        rel_hit = ft1_det.rel;
      end
      DXLC_LB_EITHER: begin
        act_hit = v54_det.act | ft1_det.act;
        rel_hit = v54_det.rel | ft1_det.rel;
      end
    endcase
  end

  assign slot_on = st.cfg.xc_map[net_slot];

  ////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    next_st = st;
    ev_set = '0;
    // Loopback start needs permission; release always honoured
    if (act_hit && lb_permit && !st.lb) begin
      next_st.lb = 1'b1;
      ev_set[DXLC_EV_LB_ON] = 1'b1;
    end else if (rel_hit && st.lb) begin
      next_st.lb = 1'b0;
      ev_set[DXLC_EV_LB_OFF] = 1'b1;
    end
    next_st.fail_d = line_fail;
    if (line_fail && !st.fail_d) begin
      ev_set[DXLC_EV_FAIL] = 1'b1;
    end
    // Register writes; write-one-to-clear, set wins
    next_st.evt = st.evt;
    if (wr) begin
      unique case (addr)
        DXLC_REG_CTRL: begin
          next_st.cfg.lb_mode = dxlc_lbmode_t'(wdata[1:0]);
          next_st.cfg.if_en = wdata[DXLC_CTRL_IFEN];
          next_st.cfg.esf = wdata[DXLC_CTRL_ESF];
          next_st.cfg.b8zs = wdata[DXLC_CTRL_B8ZS];
          next_st.cfg.aos_en = wdata[DXLC_CTRL_AOS];
        end
        DXLC_REG_IRQ: begin
          next_st.evt = st.evt & ~wdata[DXLC_EV_W-1:0];
        end
        DXLC_REG_MASK: begin
          next_st.mask = wdata[DXLC_EV_W-1:0];
        end
        DXLC_REG_XC: begin
          next_st.cfg.xc_map = wdata[DXLC_SLOTS-1:0];
        end
        default: begin
        end
      endcase
    end
    // Disabled interface drops all cross-connects and the loopback
    if (!next_st.cfg.if_en) begin
      next_st.cfg.xc_map = '0;
      next_st.lb = 1'b0;
    end
    // Alarm events suppressed while disabled
    next_st.evt = next_st.evt | (ev_set & {DXLC_EV_W{st.cfg.if_en}});
    // Read data in the cycle after the strobe
    next_st.rdata = '0;
    if (rd) begin
      unique case (addr)
        DXLC_REG_CTRL: begin
          next_st.rdata[1:0] = st.cfg.lb_mode;
          next_st.rdata[DXLC_CTRL_IFEN] = st.cfg.if_en;
          next_st.rdata[DXLC_CTRL_ESF] = st.cfg.esf;
          next_st.rdata[DXLC_CTRL_B8ZS] = st.cfg.b8zs;
          next_st.rdata[DXLC_CTRL_AOS] = st.cfg.aos_en;
        end
        DXLC_REG_STAT: begin
          next_st.rdata[0] = st.lb;
          next_st.rdata[1] = line_fail;
          next_st.rdata[2] = st.fail_d;
        end
        DXLC_REG_IRQ: begin
          next_st.rdata[DXLC_EV_W-1:0] = st.evt;
        end
        DXLC_REG_MASK: begin
          next_st.rdata[DXLC_EV_W-1:0] = st.mask;
        end
        DXLC_REG_XC: begin
          next_st.rdata[DXLC_SLOTS-1:0] = st.cfg.xc_map;
        end
        default: begin
        end
      endcase
    end
    // Data toward the network on cross-connected slots
    next_st.net_tx_vld = net_vld & slot_on;
    if (st.lb) begin
      next_st.net_tx_bit = net_bit;
    end else if (st.cfg.aos_en && line_fail) begin
      next_st.net_tx_bit = 1'b1;
    end else begin
      next_st.net_tx_bit = dsx_bit;
    end
    next_st.dsx_tx_bit = st.lb ? 1'b1 : net_bit;
    // Indicators held off while disabled
    next_st.alarm = line_fail;
    next_st.led = st.cfg.if_en & ~line_fail;
    next_st.irq = |(next_st.evt & next_st.mask);
  end

  ////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st <= '{cfg: DXLC_CFG_RST, default: '0};
    end else begin
      st <= next_st;
    end
  end

  // All outputs straight from flops
  assign rdata = st.rdata;
  assign net_tx_bit = st.net_tx_bit;
  assign net_tx_vld = st.net_tx_vld;
  assign dsx_tx_bit = st.dsx_tx_bit;
  assign data_channel_loopback = st.lb;
  assign esf_mode = st.cfg.esf;
  assign b8zs_mode = st.cfg.b8zs;
  assign alarm = st.alarm;
  assign led = st.led;
  assign irq = st.irq;

  ////////////////////////////////////////////////////////////////////
  // Assertions

  a_ignore_no_lb: assert property (@(posedge mclk) disable iff (rst)
    (st.cfg.lb_mode == DXLC_LB_IGNORE && !st.lb) |=> !st.lb)
    else $error("loopback started in ignore mode");

  a_act_starts_lb: assert property (@(posedge mclk) disable iff (rst)
    (act_hit && lb_permit && st.cfg.if_en && !wr) |=> st.lb)
    else $error("actuate did not start loopback");

  a_v54_only: assert property (@(posedge mclk) disable iff (rst)
    (st.cfg.lb_mode == DXLC_LB_V54 && ft1_det.act && !v54_det.act &&
     !st.lb) |=> !st.lb)
    else $error("FT1 pattern accepted in V.54 mode");

  a_ft1_only: assert property (@(posedge mclk) disable iff (rst)
    (st.cfg.lb_mode == DXLC_LB_FT1 && v54_det.act && !ft1_det.act &&
     !st.lb) |=> !st.lb)
    else $error("V.54 pattern accepted in FT1 mode");

  a_either_mode: assert property (@(posedge mclk) disable iff (rst)
    (st.cfg.lb_mode == DXLC_LB_EITHER && st.lb && !wr &&
     (v54_det.rel || ft1_det.rel)) |=> !st.lb)
    else $error("release ignored in either mode");

  a_disable_clear: assert property (@(posedge mclk) disable iff (rst)
    !st.cfg.if_en |-> (st.cfg.xc_map == '0 && !st.lb))
    else $error("disabled interface kept connections");

  a_led_off: assert property (@(posedge mclk) disable iff (rst)
    (!st.cfg.if_en && $past(!st.cfg.if_en)) |-> (!led && !alarm))
    else $error("indicator on while disabled");

  a_all_ones: assert property (@(posedge mclk) disable iff (rst)
    (st.cfg.aos_en && line_fail && !st.lb && !wr) |=> net_tx_bit)
    else $error("all ones not sent on failure");

  a_pass_thru: assert property (@(posedge mclk) disable iff (rst)
    (!st.cfg.aos_en && !st.lb) |=> net_tx_bit == $past(dsx_bit))
    else $error("data changed with substitution off");

  a_loop_back: assert property (@(posedge mclk) disable iff (rst)
    st.lb |=> net_tx_bit == $past(net_bit))
    else $error("loopback did not return network data");

endmodule : dxlc_top
`default_nettype wire

// ---- sim/dxlc_far_end.sv ----
// Far-end network model: repeats loopback codes and sends data bits.
// Assumes callers enter its tasks right after a rising edge of mclk.
`timescale 1ns/10ps
`default_nettype none
module dxlc_far_end (
  // Clock
  input wire logic mclk,
  // Network receive stream
  output var logic net_vld,
  output var logic net_bit,
  output var logic [4:0] net_slot
);
  // Quiet line at time zero
  initial begin
    net_vld = 1'b0;
    net_bit = 1'b0;
    net_slot = 5'h00;
  end
  ////////////////////////////////////////
  // Code repeated MSB first, one bit a cycle, slots 0..23 in turn
  task automatic send(input logic [31:0] pat, input int len, input int n);
    for (int i = 0; i < len * n; i++) begin
      net_vld <= 1'b1;
      net_bit <= pat[len - 1 - (i % len)];
      net_slot <= 5'(i % 24);
      @(posedge mclk);
    end
  endtask : send
  // Released line toggles so a stale bit never looks valid
  task automatic idle(input int n);
    net_vld <= 1'b0;
    repeat (n) begin
      net_bit <= ~net_bit;
      @(posedge mclk);
    end
  endtask : idle
endmodule : dxlc_far_end
`default_nettype wire

// ---- sim/tb.sv ----
// Bench for the DSX-1 port loopback control block.
// Assumes the far-end model drives the network stream, bench the rest.
`timescale 1ns/10ps
`default_nettype none
module tb;
  import dxlc_pkg::*;
  logic mclk, rst, wr, rd, lb_permit, dsx_bit, net_vld, net_bit;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, rv, seed;
  logic [4:0] net_slot;
  logic loss_of_signal, alarm_indication_signal, out_of_frame;
  logic net_tx_bit, net_tx_vld, dsx_tx_bit, data_channel_loopback;
  logic esf_mode, b8zs_mode, alarm, led, irq, p_bit, p_vld, p_dsx, e;
  int err_total, comparisons, cyc, src;
  dxlc_top dut_u (.mclk, .rst, .addr, .wdata, .wr, .rd, .rdata,
    .loss_of_signal, .alarm_indication_signal, .out_of_frame, .net_vld,
    .net_bit, .net_slot, .lb_permit, .dsx_bit, .net_tx_bit, .net_tx_vld,
    .dsx_tx_bit, .data_channel_loopback, .esf_mode, .b8zs_mode, .alarm,
    .led, .irq);
  dxlc_far_end far_u (.mclk, .net_vld, .net_bit, .net_slot);
  ////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  task automatic report_and_stop();
    $display("mismatches %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic chkb(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask : chkb
  // Gap cycle after each strobe so no signal is driven twice at an edge
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
    @(posedge mclk);
  endtask : wreg
  task automatic rreg(input logic [7:0] a, input logic [31:0] exp);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    // Read data stand between this edge and the next; look 1 ns after this edge
    #1;
    rv = rdata;
    @(posedge mclk);
    chk(rv, exp);
  endtask : rreg
  // V.54 codes are 7 bits, FT1 codes 10; both well past 2048 bits
  task automatic code(input int t, input int rel);
    if (t == 0) far_u.send(rel ? 32'h43 : 32'h3C, 7, 320);
    else far_u.send(rel ? 32'h0A4 : 32'h0D2, 10, 230);
    far_u.idle(4);
  endtask : code
  // Clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // Line bit toward network and hang limit
  always @(posedge mclk) begin
    dsx_bit <= seed[7];
    cyc++;
    if (cyc == 80000) begin
      err_total++;
      report_and_stop();
    end
  end
  // Network-bound bit checked one cycle after the input it answers
  always @(negedge mclk) begin
    if (src != 0) begin
      chkb(net_tx_vld, p_vld);
      if (p_vld) chkb(net_tx_bit, src == 1 ? p_bit : src == 2 | p_dsx);
    end
    p_bit = net_bit;
    p_vld = net_vld;
    p_dsx = dsx_bit;
  end
  // Main sequence
  initial begin
    seed = 32'h3B3C;
    {rst, wr, rd, addr, wdata, lb_permit, dsx_bit} = {1'b1, 44'h0};
    {loss_of_signal, alarm_indication_signal, out_of_frame} = 3'h0;
    {err_total, comparisons, cyc, src} = '0;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    lb_permit <= 1'b1;
    @(posedge mclk);
    chkb(esf_mode, 1);
    chkb(b8zs_mode, 1);
    rreg(DXLC_REG_CTRL, 32'h38);
    for (int k = 1; k < 6; k++) rreg(8'(4 * k), 0);
    wreg(DXLC_REG_CTRL, 32'h3C);
    wreg(DXLC_REG_XC, 32'hFFFFFF);
    wreg(DXLC_REG_MASK, 32'h7);
    rreg(DXLC_REG_XC, 32'hFFFFFF);
    // Every mode against both code forms
    for (int m = 0; m < 4; m++) begin
      for (int t = 0; t < 2; t++) begin
        e = (m == 3) || (m == t + 1);
        wreg(DXLC_REG_CTRL, 32'h3C | m);
        code(t, 0);
        chkb(data_channel_loopback, e);
        if (e) begin
          chkb(irq, 1);
          rreg(DXLC_REG_STAT, 32'h1);
          src = 1;
          repeat (4) far_u.send(xs(), 32, 1);
          far_u.idle(2);
          src = 0;
          chkb(dsx_tx_bit, 1);
          wreg(DXLC_REG_IRQ, 32'h7);
          code(t, 1);
          chkb(data_channel_loopback, 0);
          wreg(DXLC_REG_IRQ, 32'h7);
        end
      end
    end
    chkb(irq, 0);
    lb_permit <= 1'b0;
    code(0, 0);
    chkb(data_channel_loopback, 0);
    lb_permit <= 1'b1;
    // Line failures with substitution on
    for (int f = 0; f < 3; f++) begin
      loss_of_signal <= (f == 0);
      alarm_indication_signal <= (f == 1);
      out_of_frame <= (f == 2);
      far_u.idle(6);
      chkb(alarm, 1);
      chkb(led, 0);
      src = 2;
      repeat (3) far_u.send(xs(), 32, 1);
      far_u.idle(2);
      src = 0;
    end
    alarm_indication_signal <= 1'b0;
    out_of_frame <= 1'b0;
    far_u.idle(6);
    chkb(led, 1);
    rreg(DXLC_REG_IRQ, 32'h4);
    wreg(DXLC_REG_IRQ, 32'h4);
    chkb(irq, 0);
    // Substitution off: line data passes unchanged
    wreg(DXLC_REG_CTRL, 32'h1C);
    loss_of_signal <= 1'b1;
    far_u.idle(6);
    src = 3;
    repeat (3) far_u.send(xs(), 32, 1);
    far_u.idle(2);
    src = 0;
    // Framing and coding selections
    for (int k = 0; k < 4; k++) begin
      wreg(DXLC_REG_CTRL, 32'h04 | (k << 3));
      chkb(esf_mode, k[0]);
      chkb(b8zs_mode, k[1]);
    end
    rreg(DXLC_REG_CTRL, 32'h1C);
    // Disable clears map, silences alarm and indicator
    loss_of_signal <= 1'b0;
    wreg(DXLC_REG_IRQ, 32'h7);
    wreg(DXLC_REG_CTRL, 32'h00);
    loss_of_signal <= 1'b1;
    far_u.idle(6);
    rreg(DXLC_REG_XC, 0);
    chkb(alarm, 0);
    chkb(led, 0);
    wreg(DXLC_REG_XC, 32'hFFFFFF);
    rreg(DXLC_REG_XC, 0);
    rreg(DXLC_REG_IRQ, 0);
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
